// ### rtl/protect_pkg.sv
// Constants shared by the protection threshold logic
package protect_pkg;
   // Clock and hold timer base
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned TICK_PERIOD_NS = 2000000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // Register byte addresses
   localparam logic [7:0] HOLD_OFS   = 8'h00;
   localparam logic [7:0] ESTOP_OFS  = 8'h04;
   localparam logic [7:0] DEV_OFS    = 8'h08;
   localparam logic [7:0] ANA_OFS    = 8'h0C;
   localparam logic [7:0] OVL_OFS    = 8'h10;
   localparam logic [7:0] OVS_OFS    = 8'h14;
   localparam logic [7:0] SEL_OFS    = 8'h18;
   localparam logic [7:0] STAT_OFS   = 8'h1C;
   localparam logic [7:0] MASK_OFS   = 8'h20;
   localparam logic [7:0] ALARM_OFS  = 8'h24;
   // Reset values
   localparam logic [15:0] HOLD_RST  = 16'h0023;
   localparam logic [15:0] ESTOP_RST = 16'h0000;
   localparam logic [15:0] DEV_RST   = 16'h0064;
   localparam logic [15:0] ANA_RST   = 16'h0000;
   localparam logic [15:0] OVL_RST   = 16'h0000;
   localparam logic [15:0] OVS_RST   = 16'h0000;
   // Special setting values
   localparam logic [15:0] HOLD_OFF   = 16'h03E8;
   localparam logic [15:0] OVL_MAX    = 16'h0073;
   localparam logic [3:0]  DP_ESTOP   = 4'h2;
   localparam logic [3:0]  SEL_ESTOP8 = 4'h8;
   localparam logic [3:0]  SEL_ESTOP9 = 4'h9;
   localparam int unsigned DEV_SHIFT  = 8;
   // Overspeed ceiling is max speed * 6 / 5
   localparam logic [2:0]  OVS_MUL    = 3'h6;
   localparam logic [2:0]  OVS_DIV    = 3'h5;
   // Selection register field positions
   localparam int unsigned DP_LSB    = 0;
   localparam int unsigned SL_LSB    = 4;
   localparam int unsigned SD_LSB    = 8;
   localparam int unsigned REGEN_LSB = 12;
   // Status bit positions
   localparam int unsigned ST_LOSS = 0;
   localparam int unsigned ST_DEV  = 1;
   localparam int unsigned ST_ANA  = 2;
   localparam int unsigned ST_OVL  = 3;
   localparam int unsigned ST_OVS  = 4;
   localparam int unsigned ST_W    = 5;
   // Alarm codes
   localparam logic [7:0] ALARM_DEV = 8'h18;
   localparam logic [7:0] ALARM_ANA = 8'h27;
endpackage

// ### rtl/loss_if.sv
// Link between the threshold logic and the supply loss hold timer
`timescale 1ns/1ns
interface loss_if;
   logic [15:0] hold_time;     // Hold setting in 2 ms units
   logic        supply_absent; // Synchronised supply absent level
   logic        detected;      // Supply loss declared
   modport ctrl  (output hold_time, output supply_absent, input detected);
   modport timer (input hold_time, input supply_absent, output detected);
endinterface

// ### rtl/supply_loss_timer.sv
// Hold timer that declares main supply loss
`timescale 1ns/1ns
module supply_loss_timer #(
   parameter int unsigned TICK_CYCLES = protect_pkg::TICK_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   loss_if.timer     lt
);
   typedef struct packed {
      logic [31:0] div;      // Cycles within one 2 ms tick
      logic [15:0] ticks;    // Whole ticks of absence
      logic        detected; // Loss declared
   } tmr_t;
   tmr_t s_reg;
   tmr_t s_next;

   // Count absence in 2 ms ticks, restart when supply returns
   always_comb begin
      s_next = s_reg;
      if (!lt.supply_absent || lt.hold_time == protect_pkg::HOLD_OFF) begin
         s_next.div      = '0;
         s_next.ticks    = '0;
         s_next.detected = 1'b0;
      end else begin
         if (s_reg.div == TICK_CYCLES - 1) begin
            s_next.div = '0;
            if (s_reg.ticks != 16'hFFFF) begin
               s_next.ticks = s_reg.ticks + 16'h0001;
            end
         end else begin
            s_next.div = s_reg.div + 32'h00000001;
         end
         s_next.detected = (s_reg.ticks >= lt.hold_time);
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lt.detected = s_reg.detected;
endmodule

// ### rtl/drive_protection_thresholds.sv
// Protection threshold registers and comparators of a servo drive
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module drive_protection_thresholds #(
   parameter int unsigned TICK_CYCLES = protect_pkg::TICK_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        main_supply_present,
   input  wire logic        drive_prohibit_decel,
   input  wire logic        servo_disable_decel,
   input  wire logic [9:0]  normal_torque_limit,
   input  wire logic [23:0] deviation_magnitude,
   input  wire logic [11:0] torque_command_input,
   input  wire logic [9:0]  load_percent,
   input  wire logic [15:0] speed_rpm,
   input  wire logic [15:0] motor_max_rpm,
   output logic      [9:0]  torque_limit,
   output logic             estop_limit_active,
   output logic             supply_loss_detected,
   output logic             supply_loss_estop,
   output logic      [7:0]  alarm_code,
   output logic             irq
);
   // All block state
   typedef struct packed {
      logic                         sync1;     // Supply pin first stage
      logic                         sync2;     // Supply pin second stage
      logic [15:0]                  hold;      // Supply loss hold time
      logic [15:0]                  estop;     // Emergency stop torque
      logic [15:0]                  dev;       // Deviation overflow level
      logic [15:0]                  ana;       // Analog over-level
      logic [15:0]                  ovl;       // Overload level
      logic [15:0]                  ovs;       // Overspeed level
      logic [15:0]                  sel;       // Stop and regen selects
      logic [protect_pkg::ST_W-1:0] status;    // Sticky events
      logic [protect_pkg::ST_W-1:0] mask;      // Interrupt enables
      logic [protect_pkg::ST_W-1:0] live;      // Current conditions
      logic [7:0]                   alarm;     // Latest alarm code
      logic [9:0]                   tlim;      // Applied torque limit
      logic                         estop_on;  // Emergency limit in use
      logic                         loss_stop; // Emergency stop on loss
      logic                         ready;     // APB answer cycle
      logic                         err;       // APB error answer
      logic [31:0]                  rdata;     // APB read data
   } state_t;
   state_t s_reg;
   state_t s_next;

   loss_if lif ();

   // Supply loss hold timer
   supply_loss_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .lt      (lif.timer)
   );

   assign lif.hold_time     = s_reg.hold;
   assign lif.supply_absent = !s_reg.sync2;

   // Address decode shared by read and write
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         protect_pkg::HOLD_OFS, protect_pkg::ESTOP_OFS,
         protect_pkg::DEV_OFS, protect_pkg::ANA_OFS,
         protect_pkg::OVL_OFS, protect_pkg::OVS_OFS,
         protect_pkg::SEL_OFS, protect_pkg::STAT_OFS,
         protect_pkg::MASK_OFS, protect_pkg::ALARM_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // Emergency select code check
   function automatic logic is_estop(input logic [3:0] v);
      is_estop = (v == protect_pkg::SEL_ESTOP8) || (v == protect_pkg::SEL_ESTOP9);
   endfunction

   // Comparator intermediates
   logic [22:0] dev_thr;   // Deviation threshold in pulses
   logic [15:0] ovl_eff;   // Effective overload percent
   logic [19:0] ovs_ceil;  // Ceiling times five
   logic [19:0] ovs_set5;  // Setting times five
   logic [19:0] ovs_eff5;  // Effective level times five
   logic [19:0] spd5;      // Speed times five
   logic [3:0]  dp_sel;    // Drive prohibit select
   logic [3:0]  sl_sel;    // Supply loss select
   logic [3:0]  sd_sel;    // Servo disable select
   logic        dev_over;  // Deviation over threshold
   logic        ana_over;  // Command over threshold
   logic        ovl_over;  // Load over level
   logic        ovs_over;  // Speed over level
   logic        loss_est;  // Emergency stop after loss
   logic        want_est;  // Emergency limit wanted
   logic        acc;       // APB access phase
   logic        wr;        // Write takes effect
   logic [protect_pkg::ST_W-1:0] events; // Condition vector

   assign dp_sel = s_reg.sel[protect_pkg::DP_LSB +: 4];
   assign sl_sel = s_reg.sel[protect_pkg::SL_LSB +: 4];
   assign sd_sel = s_reg.sel[protect_pkg::SD_LSB +: 4];

   // Threshold comparisons, evaluated every cycle
   always_comb begin
      dev_thr  = {s_reg.dev[14:0], 8'h00};
      dev_over = (s_reg.dev != 16'h0000)
                 && ({1'b0, dev_thr} < deviation_magnitude);
      // Analog threshold in 0.1 V, zero disables
      ana_over = (s_reg.ana != 16'h0000)
                 && ({4'h0, torque_command_input} > s_reg.ana);
      // Overload level, zero or excess selects the ceiling
      if (s_reg.ovl == 16'h0000 || s_reg.ovl > protect_pkg::OVL_MAX) begin
         ovl_eff = protect_pkg::OVL_MAX;
      end else begin
         ovl_eff = s_reg.ovl;
      end
      ovl_over = {6'h00, load_percent} > ovl_eff;
      // Overspeed compared in fifths to avoid a divider
      ovs_ceil = 20'(motor_max_rpm) * 20'(protect_pkg::OVS_MUL);
      ovs_set5 = 20'(s_reg.ovs) * 20'(protect_pkg::OVS_DIV);
      spd5     = 20'(speed_rpm) * 20'(protect_pkg::OVS_DIV);
      if (s_reg.ovs == 16'h0000 || ovs_set5 > ovs_ceil) begin
         ovs_eff5 = ovs_ceil;
      end else begin
         ovs_eff5 = ovs_set5;
      end
      ovs_over = spd5 > ovs_eff5;
      // Emergency torque limit selection
      loss_est = lif.detected && is_estop(sl_sel);
      want_est = (drive_prohibit_decel && dp_sel == protect_pkg::DP_ESTOP)
                 || loss_est
                 || (servo_disable_decel && is_estop(sd_sel));
      events = '0;
      events[protect_pkg::ST_LOSS] = lif.detected;
      events[protect_pkg::ST_DEV]  = dev_over;
      events[protect_pkg::ST_ANA]  = ana_over;
      events[protect_pkg::ST_OVL]  = ovl_over;
      events[protect_pkg::ST_OVS]  = ovs_over;
   end

   assign acc = psel && penable;
   assign wr  = acc && s_reg.ready && pwrite && !s_reg.err;

   // Next state: synchroniser, registers, alarms, APB
   always_comb begin
      s_next       = s_reg;
      s_next.sync1 = main_supply_present;
      s_next.sync2 = s_reg.sync1;
      // Settings written by software
      if (wr) begin
         case (paddr)
            protect_pkg::HOLD_OFS:  s_next.hold  = pwdata[15:0];
            protect_pkg::ESTOP_OFS: s_next.estop = pwdata[15:0];
            protect_pkg::DEV_OFS:   s_next.dev   = pwdata[15:0];
            protect_pkg::ANA_OFS:   s_next.ana   = pwdata[15:0];
            protect_pkg::OVL_OFS:   s_next.ovl   = pwdata[15:0];
            protect_pkg::OVS_OFS:   s_next.ovs   = pwdata[15:0];
            protect_pkg::SEL_OFS:   s_next.sel   = pwdata[15:0];
            protect_pkg::MASK_OFS:  s_next.mask  = pwdata[protect_pkg::ST_W-1:0];
            protect_pkg::STAT_OFS: begin
               // Write one clears
               s_next.status = s_reg.status & ~pwdata[protect_pkg::ST_W-1:0];
            end
            default: begin
               s_next.hold = s_reg.hold;
            end
         endcase
      end
      // New events set, winning over a clear
      s_next.status = s_next.status | events;
      s_next.live   = events;
      // Latest documented alarm code
      if (dev_over) begin
         s_next.alarm = protect_pkg::ALARM_DEV;
      end else if (ana_over) begin
         s_next.alarm = protect_pkg::ALARM_ANA;
      end
      // Applied torque limit
      s_next.estop_on  = want_est && (s_reg.estop != 16'h0000);
      s_next.loss_stop = loss_est;
      if (want_est && s_reg.estop != 16'h0000) begin
         s_next.tlim = s_reg.estop[9:0];
      end else begin
         s_next.tlim = normal_torque_limit;
      end
      // APB: one wait state, answer registered
      if (acc && !s_reg.ready) begin
         s_next.ready = 1'b1;
         s_next.err   = !mapped(paddr);
         s_next.rdata = '0;
         case (paddr)
            protect_pkg::HOLD_OFS:  s_next.rdata[15:0] = s_reg.hold;
            protect_pkg::ESTOP_OFS: s_next.rdata[15:0] = s_reg.estop;
            protect_pkg::DEV_OFS:   s_next.rdata[15:0] = s_reg.dev;
            protect_pkg::ANA_OFS:   s_next.rdata[15:0] = s_reg.ana;
            protect_pkg::OVL_OFS:   s_next.rdata[15:0] = s_reg.ovl;
            protect_pkg::OVS_OFS:   s_next.rdata[15:0] = s_reg.ovs;
            protect_pkg::SEL_OFS:   s_next.rdata[15:0] = s_reg.sel;
            protect_pkg::STAT_OFS: begin
               s_next.rdata[protect_pkg::ST_W-1:0] = s_reg.status;
            end
            protect_pkg::MASK_OFS: begin
               s_next.rdata[protect_pkg::ST_W-1:0] = s_reg.mask;
            end
            protect_pkg::ALARM_OFS: begin
               // Alarm code low, live conditions above
               s_next.rdata[7:0] = s_reg.alarm;
               s_next.rdata[8 +: protect_pkg::ST_W] = s_reg.live;
            end
            default: begin
               s_next.rdata = '0;
            end
         endcase
      end else begin
         s_next.ready = 1'b0;
         s_next.err   = 1'b0;
      end
   end

   // State register with reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg       <= '0;
         s_reg.hold  <= protect_pkg::HOLD_RST;
         s_reg.estop <= protect_pkg::ESTOP_RST;
         s_reg.dev   <= protect_pkg::DEV_RST;
         s_reg.ana   <= protect_pkg::ANA_RST;
         s_reg.ovl   <= protect_pkg::OVL_RST;
         s_reg.ovs   <= protect_pkg::OVS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs
   assign prdata               = s_reg.ready ? s_reg.rdata : 32'h00000000;
   assign pready               = s_reg.ready;
   assign pslverr              = s_reg.ready && s_reg.err;
   assign torque_limit         = s_reg.tlim;
   assign estop_limit_active   = s_reg.estop_on;
   assign supply_loss_detected = s_reg.live[protect_pkg::ST_LOSS];
   assign supply_loss_estop    = s_reg.loss_stop;
   assign alarm_code           = s_reg.alarm;
   assign irq                  = |(s_reg.status & s_reg.mask);
endmodule

// ### testbench/drive_protection_thresholds_properties.sv
// Port checker for the protection threshold block
`timescale 1ns/1ns
module drive_protection_thresholds_properties #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        main_supply_present,
   input wire logic        drive_prohibit_decel,
   input wire logic        servo_disable_decel,
   input wire logic [9:0]  normal_torque_limit,
   input wire logic [23:0] deviation_magnitude,
   input wire logic [11:0] torque_command_input,
   input wire logic [9:0]  torque_limit,
   input wire logic        supply_loss_detected,
   input wire logic [7:0]  alarm_code
);
   logic [15:0] hold_s, est_s, dev_s, ana_s, sel_s; // Settings as last written
   logic [31:0] gone; // Cycles with supply absent
   logic        dev_hit; // Overflow condition
   logic        decel_on; // Emergency decel selected
   assign dev_hit  = dev_s != 16'h0 && deviation_magnitude > {1'b0, dev_s[14:0], 8'h00};
   assign decel_on = (drive_prohibit_decel && sel_s[3:0] == 4'h2) ||
                     (servo_disable_decel && sel_s[11:9] == 3'h4);
   // Shadow settings as writes complete
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_s <= protect_pkg::HOLD_RST;
         est_s  <= protect_pkg::ESTOP_RST;
         dev_s  <= protect_pkg::DEV_RST;
         ana_s  <= protect_pkg::ANA_RST;
         sel_s  <= 16'h0000;
         gone   <= 32'h0;
      end else begin
         gone <= main_supply_present ? 32'h0 : gone + 32'h1;
         if (psel && penable && pready && pwrite) begin
            case (paddr)
               protect_pkg::HOLD_OFS:  hold_s <= pwdata[15:0];
               protect_pkg::ESTOP_OFS: est_s <= pwdata[15:0];
               protect_pkg::DEV_OFS:   dev_s <= pwdata[15:0];
               protect_pkg::ANA_OFS:   ana_s <= pwdata[15:0];
               protect_pkg::SEL_OFS:   sel_s <= pwdata[15:0];
               default:                ;
            endcase
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_idle_data: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   a_dev_alarm: assert property (dev_hit |=> alarm_code == 8'h18)
      else $error("overflow alarm missing");
   a_dev_off: assert property (dev_s == 16'h0 && alarm_code != 8'h18 |=> alarm_code != 8'h18)
      else $error("overflow alarm while off");
   a_ana_alarm: assert property (ana_s != 16'h0 && {4'h0, torque_command_input} > ana_s
      && !dev_hit |=> alarm_code == 8'h27) else $error("analog alarm missing");
   a_estop_torque: assert property (est_s != 16'h0 && decel_on
      |=> torque_limit == $past(est_s[9:0])) else $error("emergency limit not used");
   a_normal_torque: assert property (est_s == 16'h0
      |=> torque_limit == $past(normal_torque_limit)) else $error("normal limit not used");
   a_hold_off: assert property ((hold_s == protect_pkg::HOLD_OFF)[*3] |-> !supply_loss_detected)
      else $error("loss declared while off");
   a_loss_early: assert property ($rose(supply_loss_detected) |-> gone >= hold_s * TICK_CYCLES)
      else $error("loss declared early");
   a_loss_late: assert property (!main_supply_present && hold_s != protect_pkg::HOLD_OFF &&
      gone == hold_s * TICK_CYCLES + 2 * TICK_CYCLES + 8 |-> supply_loss_detected)
      else $error("loss declared late");
endmodule
bind drive_protection_thresholds drive_protection_thresholds_properties #(
   .TICK_CYCLES(TICK_CYCLES)
) i_drive_protection_thresholds_properties (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .main_supply_present, .drive_prohibit_decel, .servo_disable_decel, .normal_torque_limit,
   .deviation_magnitude, .torque_command_input, .torque_limit, .supply_loss_detected,
   .alarm_code
);

// ### testbench/servo_loops_model.sv
// Model of the control loops and analog command input
`timescale 1ns/1ns
module servo_loops_model (
   input  wire logic        pclk,
   output logic             main_supply_present,
   output logic             drive_prohibit_decel,
   output logic             servo_disable_decel,
   output logic      [9:0]  normal_torque_limit,
   output logic      [23:0] deviation_magnitude,
   output logic      [11:0] torque_command_input,
   output logic      [9:0]  load_percent,
   output logic      [15:0] speed_rpm,
   output logic      [15:0] motor_max_rpm
);
   // Healthy machine at rest from time zero
   initial begin
      {main_supply_present, drive_prohibit_decel, servo_disable_decel} = 3'h4;
      {normal_torque_limit, deviation_magnitude, torque_command_input} = 46'h0;
      {load_percent, speed_rpm, motor_max_rpm} = {10'h0, 16'h0, 16'h0BB8};
   end
   // New measurements appear just after an edge
   task automatic meas(input logic [23:0] dv, input logic [11:0] cm, input logic [9:0] ld,
                       input logic [15:0] sp);
      @(posedge pclk);
      {deviation_magnitude, torque_command_input, load_percent, speed_rpm} <= {dv, cm, ld, sp};
   endtask
   // Supply, deceleration states and motor limits
   task automatic state(input logic su, input logic dp, input logic sd, input logic [9:0] nt,
                        input logic [15:0] mx);
      @(posedge pclk);
      {main_supply_present, drive_prohibit_decel, servo_disable_decel} <= {su, dp, sd};
      {normal_torque_limit, motor_max_rpm} <= {nt, mx};
   endtask
endmodule

// ### testbench/drive_protection_thresholds_tb.sv
// Self-checking bench of the protection threshold block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_fail++; \
   $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module drive_protection_thresholds_tb;
   localparam int unsigned TICK = 4;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr, alarm_code;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, rerr, irq;
   logic        main_supply_present, drive_prohibit_decel, servo_disable_decel;
   logic [9:0]  normal_torque_limit, load_percent, torque_limit;
   logic [23:0] deviation_magnitude;
   logic [11:0] torque_command_input;
   logic [15:0] speed_rpm, motor_max_rpm;
   logic        estop_limit_active, supply_loss_detected, supply_loss_estop;
   logic [15:0] mdl [8];
   logic [15:0] selv [4] = '{16'h0002, 16'h0800, 16'h0900, 16'h0001};
   int          maxv [6] = '{1000, 500, 32767, 100, 115, 20000};
   int          ovl [4]  = '{0, 60, 115, 300};
   int          ovs [3];
   int          n_fail, comparisons, s, e, n, lim;
   drive_protection_thresholds #(.TICK_CYCLES(TICK)) i_drive_protection_thresholds (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .main_supply_present, .drive_prohibit_decel, .servo_disable_decel, .normal_torque_limit,
      .deviation_magnitude, .torque_command_input, .load_percent, .speed_rpm, .motor_max_rpm,
      .torque_limit, .estop_limit_active, .supply_loss_detected, .supply_loss_estop,
      .alarm_code, .irq);
   servo_loops_model i_servo_loops_model (
      .pclk, .main_supply_present, .drive_prohibit_decel, .servo_disable_decel,
      .normal_torque_limit, .deviation_magnitude, .torque_command_input, .load_percent,
      .speed_rpm, .motor_max_rpm);
   // Free running bus clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // One bus transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_fail++;
      {rdat, rerr} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a < protect_pkg::STAT_OFS) mdl[a[4:2]] = d[15:0];
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK("register", x, rdat)
   endtask
   task automatic chkbit(input logic [7:0] a, input int b, input logic x);
      apb(1'b0, a, 32'h0);
      `CHK("status bit", x, rdat[b])
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask
   // Live flag low at the limit, high one past it
   task automatic pair(input logic [9:0] l0, input logic [15:0] s0, input logic [9:0] l1,
                       input logic [15:0] s1, input int b);
      i_servo_loops_model.meas(24'h0, 12'h0, l0, s0);
      settle();
      chkbit(protect_pkg::ALARM_OFS, b, 1'b0);
      i_servo_loops_model.meas(24'h0, 12'h0, l1, s1);
      settle();
      chkbit(protect_pkg::ALARM_OFS, b, 1'b1);
   endtask
   task automatic print_verdict();
      $display("Checks %0d failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = 44'h0;
      void'($urandom(59));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, random readback, unmapped address
      foreach (maxv[i]) rchk(8'(4 * i), {16'h0, i == 0 ? 16'h0023 : i == 2 ? 16'h0064 : 16'h0});
      foreach (maxv[i]) begin
         wr(8'(4 * i), {16'hFFFF, 16'($urandom_range(maxv[i]))});
         rchk(8'(4 * i), {16'h0, mdl[i]});
      end
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 1'b1, rerr)
      // Deviation and analog alarms at their thresholds
      s = $urandom_range(32767, 1);
      wr(protect_pkg::DEV_OFS, 32'(s));
      i_servo_loops_model.meas(24'(s * 256), 12'h0, 10'h0, 16'h0);
      settle();
      `CHK("alarm", 8'h00, alarm_code)
      i_servo_loops_model.meas(24'(s * 256 + 1), 12'h0, 10'h0, 16'h0);
      settle();
      `CHK("alarm", 8'h18, alarm_code)
      e = $urandom_range(100, 1);
      wr(protect_pkg::ANA_OFS, 32'(e));
      i_servo_loops_model.meas(24'h0, 12'(e), 10'h0, 16'h0);
      settle();
      `CHK("alarm", 8'h18, alarm_code)
      i_servo_loops_model.meas(24'h0, 12'(e + 1), 10'h0, 16'h0);
      settle();
      `CHK("alarm", 8'h27, alarm_code)
      // Zero settings switch both alarms off
      wr(protect_pkg::DEV_OFS, 32'h0);
      wr(protect_pkg::ANA_OFS, 32'h0);
      i_servo_loops_model.meas(24'hFFFFFF, 12'hFFF, 10'h0, 16'h0);
      wr(protect_pkg::STAT_OFS, 32'h1F);
      settle();
      chkbit(protect_pkg::STAT_OFS, protect_pkg::ST_DEV, 1'b0);
      chkbit(protect_pkg::STAT_OFS, protect_pkg::ST_ANA, 1'b0);
      `CHK("alarm", 8'h27, alarm_code)
      // Overload level, zero and oversize both mean 115
      foreach (ovl[i]) begin
         wr(protect_pkg::OVL_OFS, 32'(ovl[i]));
         e = (ovl[i] == 0 || ovl[i] > 115) ? 115 : ovl[i];
         pair(10'(e), 16'h0, 10'(e + 1), 16'h0, 8 + protect_pkg::ST_OVL);
      end
      // Overspeed level against 1.2 times the motor maximum
      lim = $urandom_range(6000, 1000);
      i_servo_loops_model.state(1'b1, 1'b0, 1'b0, 10'h64, 16'(lim));
      ovs = '{0, lim / 2, 20000};
      foreach (ovs[i]) begin
         wr(protect_pkg::OVS_OFS, 32'(ovs[i]));
         n = (ovs[i] == 0 || ovs[i] * 5 > lim * 6) ? lim * 6 : ovs[i] * 5;
         pair(10'h0, 16'(n / 5), 10'h0, 16'(n / 5 + 1), 8 + protect_pkg::ST_OVS);
      end
      // Emergency torque limit under each selection
      e = $urandom_range(500, 1);
      n = $urandom_range(300, 1);
      wr(protect_pkg::ESTOP_OFS, 32'(e));
      foreach (selv[i]) begin
         wr(protect_pkg::SEL_OFS, 32'(selv[i]));
         i_servo_loops_model.state(1'b1, selv[i][3:0] != 0, selv[i][3:0] == 0, 10'(n), 16'(lim));
         settle();
         `CHK("limit", 10'(i < 3 ? e : n), torque_limit)
         `CHK("limit on", i < 3, estop_limit_active)
      end
      wr(protect_pkg::ESTOP_OFS, 32'h0);
      wr(protect_pkg::SEL_OFS, 32'h0002);
      settle();
      `CHK("limit", 10'(n), torque_limit)
      // Supply loss at the shortest hold, emergency stop selected
      wr(protect_pkg::ESTOP_OFS, 32'(e));
      wr(protect_pkg::HOLD_OFS, 32'h23);
      wr(protect_pkg::SEL_OFS, 32'h0080);
      wr(protect_pkg::MASK_OFS, 32'h1);
      `CHK("irq", 1'b0, irq)
      i_servo_loops_model.state(1'b0, 1'b0, 1'b0, 10'(n), 16'(lim));
      s = 0;
      while (supply_loss_detected !== 1'b1 && s < 40 * TICK + 20) begin
         @(posedge pclk);
         s++;
      end
      `CHK("hold", 1'b1, s >= 35 * TICK && s < 40 * TICK + 20)
      settle();
      `CHK("loss stop", 1'b1, supply_loss_estop)
      `CHK("limit", 10'(e), torque_limit)
      `CHK("irq", 1'b1, irq)
      wr(protect_pkg::MASK_OFS, 32'h0);
      `CHK("irq", 1'b0, irq)
      i_servo_loops_model.state(1'b1, 1'b0, 1'b0, 10'(n), 16'(lim));
      settle();
      wr(protect_pkg::STAT_OFS, 32'h1F);
      chkbit(protect_pkg::STAT_OFS, protect_pkg::ST_LOSS, 1'b0);
      wr(protect_pkg::HOLD_OFS, 32'h3E8);
      i_servo_loops_model.state(1'b0, 1'b0, 1'b0, 10'(n), 16'(lim));
      repeat (300) @(posedge pclk);
      `CHK("loss", 1'b0, supply_loss_detected)
      print_verdict();
   end
endmodule
